// >>> src/fiwc_top.sv
`timescale 1ns/1ps

module fiwc_top #(
    parameter int ADDR_HI_BITS  = 6,
    parameter int TIMEOUT_TICKS = fiwc_pkg::TIMEOUT_TICKS
) (
    // Clock and reset
    input  wire logic                 clk_in,
    input  wire logic                 rstn_in,
    // Register port
    input  wire fiwc_pkg::fiwc_bus_t  bus_in,
    output logic [7:0]                rdata_out,
    // Slow sub clock, asynchronous
    input  wire logic                 slow_sub_clock_in,
    // Flash array side
    output logic                      flash_req_valid_out,
    output fiwc_pkg::fiwc_req_t       flash_req_out,
    input  wire logic                 flash_done_in,
    input  wire logic [15:0]          flash_rdata_in,
    // Status
    output logic                      write_enabled_out,
    output logic                      cpu_stall_out
);

    typedef struct packed {
        fiwc_pkg::fiwc_state_t state;
        logic [7:0]            ctrl;
        logic                  wbuf_clear;
        logic [7:0]            addr_lo;
        logic [5:0]            addr_hi;
        logic [3:0][15:0]      words;
        logic [7:0]            rdata;
        logic                  req_valid;
        fiwc_pkg::fiwc_req_t   req;
        logic                  sub_sync1;
        logic                  sub_sync2;
        logic                  sub_prev;
    } fiwc_top_regs_t;

    localparam logic [5:0] HI_MASK = 6'((1 << ADDR_HI_BITS) - 1);

    fiwc_top_regs_t r;
    fiwc_top_regs_t next_r;

    logic       sub_tick;
    logic       unl_start;
    logic       unl_active;
    logic       unl_success;
    logic       pat_wr;
    logic [2:0] pat_pos;

    ////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    function automatic logic [7:0] erase_unit(input logic [5:0] hi,
                                              input logic [7:0] lo);
        logic [7:0] u;
        u = 8'h00;
        if (ADDR_HI_BITS == 4)
        begin
            u = {4'h0, hi[3:0]};
        end
        else if (ADDR_HI_BITS == 5)
        begin
            u = {hi[4:0], lo[7:5]};
        end
        else
        begin
            u = {hi[5:0], lo[7:6]};
        end
        return u;
    endfunction

    function automatic logic is_word_reg(input logic [3:0] a);
        return a >= fiwc_pkg::REG_WORD_BASE &&
               a <= fiwc_pkg::REG_WORD_LAST;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Sub clock crossing and unlock sequencer

    // Only the second stage feeds the edge detector
    assign sub_tick = r.sub_sync2 & ~r.sub_prev;

    assign unl_start = bus_in.wr && r.state == fiwc_pkg::FIWC_ST_IDLE &&
        bus_in.addr == fiwc_pkg::REG_CTRL &&
        bus_in.wdata[fiwc_pkg::CTRL_MODE_LSB +: 3] ==
            fiwc_pkg::MODE_UNLOCK &&
        bus_in.wdata[fiwc_pkg::CTRL_PROC_BIT];

    // Writes to word 1..3 bytes are pattern candidates; word 0 is not
    assign pat_wr  = bus_in.wr && r.state == fiwc_pkg::FIWC_ST_IDLE &&
        bus_in.addr >= fiwc_pkg::REG_PAT_FIRST &&
        bus_in.addr <= fiwc_pkg::REG_WORD_LAST;
    assign pat_pos = 3'(bus_in.addr - fiwc_pkg::REG_PAT_FIRST);

    fiwc_unlock #(
        .TIMEOUT_TICKS (TIMEOUT_TICKS)
    ) u_unlock (
        .clk_in      (clk_in),
        .rstn_in     (rstn_in),
        .start_in    (unl_start),
        .sub_tick_in (sub_tick),
        .byte_wr_in  (pat_wr),
        .byte_pos_in (pat_pos),
        .byte_in     (bus_in.wdata),
        .active_out  (unl_active),
        .success_out (unl_success)
    );

    ////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb
    begin
        logic [7:0] w;
        logic [2:0] mode;
        logic [3:0] widx;
        logic       wen;
        logic       start_w;
        logic       start_r;
        w       = bus_in.wdata;
        mode    = w[fiwc_pkg::CTRL_MODE_LSB +: 3];
        widx    = bus_in.addr - fiwc_pkg::REG_WORD_BASE;
        wen     = r.ctrl[fiwc_pkg::CTRL_WEN_BIT];
        start_w = 1'b0;
        start_r = 1'b0;
        next_r  = r;

        next_r.sub_sync1 = slow_sub_clock_in;
        next_r.sub_sync2 = r.sub_sync1;
        next_r.sub_prev  = r.sub_sync2;
        next_r.req_valid = 1'b0;

        // Register reads
        if (bus_in.rd)
        begin
            if (bus_in.addr == fiwc_pkg::REG_CTRL)
            begin
                next_r.rdata = r.ctrl;
            end
            else if (bus_in.addr == fiwc_pkg::REG_WBCLR)
            begin
                next_r.rdata = {7'h00, r.wbuf_clear};
            end
            else if (bus_in.addr == fiwc_pkg::REG_ADDR_LO)
            begin
                next_r.rdata = r.addr_lo;
            end
            else if (bus_in.addr == fiwc_pkg::REG_ADDR_HI)
            begin
                next_r.rdata = {2'b00, r.addr_hi & HI_MASK};
            end
            else if (is_word_reg(bus_in.addr))
            begin
                next_r.rdata = widx[0] ? r.words[widx[2:1]][15:8]
                                       : r.words[widx[2:1]][7:0];
            end
            else
            begin
                next_r.rdata = fiwc_pkg::BYTE_RESET;
            end
        end

        // Register writes; ignored while an operation runs
        if (bus_in.wr && r.state == fiwc_pkg::FIWC_ST_IDLE)
        begin
            if (bus_in.addr == fiwc_pkg::REG_CTRL)
            begin
                next_r.ctrl[6:0] = w[6:0];
                next_r.ctrl[fiwc_pkg::CTRL_WSTART_BIT] = 1'b0;
                next_r.ctrl[fiwc_pkg::CTRL_RSTART_BIT] = 1'b0;
                if (!w[fiwc_pkg::CTRL_WEN_BIT])
                begin
                    next_r.ctrl[fiwc_pkg::CTRL_WEN_BIT] = 1'b0;
                end
                // Combined start bits in one write are refused
                if (w[fiwc_pkg::CTRL_WSTART_BIT] &&
                    !w[fiwc_pkg::CTRL_RSTART_BIT] &&
                    !w[fiwc_pkg::CTRL_RDEN_BIT] && wen &&
                    w[fiwc_pkg::CTRL_WEN_BIT] &&
                    (mode == fiwc_pkg::MODE_WRITE ||
                     mode == fiwc_pkg::MODE_ERASE))
                begin
                    start_w = 1'b1;
                end
                if (w[fiwc_pkg::CTRL_RSTART_BIT] &&
                    w[fiwc_pkg::CTRL_RDEN_BIT] &&
                    !w[fiwc_pkg::CTRL_WSTART_BIT] &&
                    mode == fiwc_pkg::MODE_READ)
                begin
                    start_r = 1'b1;
                end
            end
            else if (bus_in.addr == fiwc_pkg::REG_WBCLR)
            begin
                if (w[fiwc_pkg::WBCLR_BIT])
                begin
                    next_r.wbuf_clear = 1'b1;
                    next_r.state      = fiwc_pkg::FIWC_ST_CLR;
                    next_r.req_valid  = 1'b1;
                    next_r.req.op     = fiwc_pkg::FIWC_OP_CLEAR;
                end
            end
            else if (bus_in.addr == fiwc_pkg::REG_ADDR_LO)
            begin
                next_r.addr_lo = w;
            end
            else if (bus_in.addr == fiwc_pkg::REG_ADDR_HI)
            begin
                next_r.addr_hi = w[5:0] & HI_MASK;
            end
            else if (is_word_reg(bus_in.addr))
            begin
                if (widx[0])
                begin
                    next_r.words[widx[2:1]][15:8] = w;
                end
                else
                begin
                    next_r.words[widx[2:1]][7:0] = w;
                end
            end
        end

        // Launch an array operation with the staged address and data
        if (start_w || start_r)
        begin
            next_r.state          = fiwc_pkg::FIWC_ST_OP;
            next_r.req_valid      = 1'b1;
            next_r.req.addr       = {r.addr_hi, r.addr_lo};
            next_r.req.erase_unit = erase_unit(r.addr_hi, r.addr_lo);
            next_r.req.data       = r.words;
            if (start_r)
            begin
                next_r.req.op = fiwc_pkg::FIWC_OP_READ;
                next_r.ctrl[fiwc_pkg::CTRL_RSTART_BIT] = 1'b1;
            end
            else
            begin
                next_r.req.op = (mode == fiwc_pkg::MODE_ERASE)
                    ? fiwc_pkg::FIWC_OP_ERASE : fiwc_pkg::FIWC_OP_WRITE;
                next_r.ctrl[fiwc_pkg::CTRL_WSTART_BIT] = 1'b1;
            end
        end

        // Completion from the array
        if (flash_done_in)
        begin
            if (r.state == fiwc_pkg::FIWC_ST_OP)
            begin
                next_r.state = fiwc_pkg::FIWC_ST_IDLE;
                next_r.ctrl[fiwc_pkg::CTRL_WSTART_BIT] = 1'b0;
                next_r.ctrl[fiwc_pkg::CTRL_RSTART_BIT] = 1'b0;
                if (r.req.op == fiwc_pkg::FIWC_OP_READ)
                begin
                    next_r.words[0] = flash_rdata_in;
                end
            end
            else if (r.state == fiwc_pkg::FIWC_ST_CLR)
            begin
                next_r.state      = fiwc_pkg::FIWC_ST_IDLE;
                next_r.wbuf_clear = 1'b0;
            end
        end

        // The processor runs during a buffer clear, so it may drop status
        if (bus_in.wr && bus_in.addr == fiwc_pkg::REG_CTRL &&
            !w[fiwc_pkg::CTRL_WEN_BIT] &&
            r.state == fiwc_pkg::FIWC_ST_CLR)
        begin
            next_r.ctrl[fiwc_pkg::CTRL_WEN_BIT] = 1'b0;
        end

        // Hardware set wins over a software clear in the same cycle
        if (unl_success)
        begin
            next_r.ctrl[fiwc_pkg::CTRL_WEN_BIT] = 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            r            <= '0;
            r.state      <= fiwc_pkg::FIWC_ST_IDLE;
            r.ctrl       <= fiwc_pkg::CTRL_RESET;
            r.req.op     <= fiwc_pkg::FIWC_OP_WRITE;
            r.addr_lo    <= fiwc_pkg::BYTE_RESET;
            r.words      <= {4{fiwc_pkg::WORD_RESET}};
        end
        else
        begin
            r <= next_r;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    assign rdata_out           = r.rdata;
    assign flash_req_valid_out = r.req_valid;
    assign flash_req_out       = r.req;
    assign write_enabled_out   = r.ctrl[fiwc_pkg::CTRL_WEN_BIT];
    // Buffer clear does not stall; the processor may poll its bit
    assign cpu_stall_out       = r.state == fiwc_pkg::FIWC_ST_OP;

endmodule

// >>> src/fiwc_pkg.sv
package fiwc_pkg;

    // Register indices on the internal data-memory register port
    localparam int          REG_AW        = 4;
    localparam logic [3:0]  REG_CTRL      = 4'h0;
    localparam logic [3:0]  REG_WBCLR     = 4'h1;
    localparam logic [3:0]  REG_ADDR_LO   = 4'h2;
    localparam logic [3:0]  REG_ADDR_HI   = 4'h3;
    localparam logic [3:0]  REG_WORD_BASE = 4'h4;
    localparam logic [3:0]  REG_WORD_LAST = 4'hB;
    localparam logic [3:0]  REG_PAT_FIRST = 4'h6;

    // Control register field positions
    localparam int CTRL_WEN_BIT    = 7;
    localparam int CTRL_MODE_LSB   = 4;
    localparam int CTRL_PROC_BIT   = 3;
    localparam int CTRL_WSTART_BIT = 2;
    localparam int CTRL_RDEN_BIT   = 1;
    localparam int CTRL_RSTART_BIT = 0;
    localparam int WBCLR_BIT       = 0;

    // Reset values
    localparam logic [7:0]  CTRL_RESET    = 8'h70;
    localparam logic [7:0]  BYTE_RESET    = 8'h00;
    localparam logic [15:0] WORD_RESET    = 16'h0000;

    // Operation mode codes
    localparam logic [2:0]  MODE_WRITE    = 3'h0;
    localparam logic [2:0]  MODE_ERASE    = 3'h1;
    localparam logic [2:0]  MODE_READ     = 3'h3;
    localparam logic [2:0]  MODE_UNLOCK   = 3'h6;

    // Unlock pattern, element 0 goes to word 1 low byte
    localparam int          PAT_LEN       = 6;
    localparam logic [5:0][7:0] UNLOCK_PATTERN =
        {8'h40, 8'hC3, 8'h09, 8'h0D, 8'h04, 8'h00};

    // Unlock timeout in sub clock periods
    localparam int          TIMEOUT_US    = 300;
    localparam int          SUB_CLK_HZ    = 32768;
    localparam int          TIMEOUT_TICKS_RAW =
        (TIMEOUT_US * SUB_CLK_HZ) / 1000000;
    localparam int          TIMEOUT_TICKS =
        (TIMEOUT_TICKS_RAW < 1) ? 1 : TIMEOUT_TICKS_RAW;
    localparam int          TIMEOUT_CW    = 16;

    // Flash array operation kinds
    typedef enum logic [3:0] {
        FIWC_OP_WRITE = 4'b0001,
        FIWC_OP_ERASE = 4'b0010,
        FIWC_OP_READ  = 4'b0100,
        FIWC_OP_CLEAR = 4'b1000
    } fiwc_op_t;

    typedef enum logic [2:0] {
        FIWC_ST_IDLE = 3'b001,
        FIWC_ST_OP   = 3'b010,
        FIWC_ST_CLR  = 3'b100
    } fiwc_state_t;

    typedef struct packed {
        logic [REG_AW-1:0] addr;
        logic              wr;
        logic              rd;
        logic [7:0]        wdata;
    } fiwc_bus_t;

    typedef struct packed {
        fiwc_op_t          op;
        logic [13:0]       addr;
        logic [7:0]        erase_unit;
        logic [3:0][15:0]  data;
    } fiwc_req_t;

endpackage

// >>> src/fiwc_unlock.sv
`timescale 1ns/1ps

module fiwc_unlock #(
    parameter int TIMEOUT_TICKS = fiwc_pkg::TIMEOUT_TICKS
) (
    // Clock and reset
    input  wire logic       clk_in,
    input  wire logic       rstn_in,
    // Control
    input  wire logic       start_in,
    input  wire logic       sub_tick_in,
    // Pattern byte writes
    input  wire logic       byte_wr_in,
    input  wire logic [2:0] byte_pos_in,
    input  wire logic [7:0] byte_in,
    // Result
    output logic            active_out,
    output logic            success_out
);

    typedef struct packed {
        logic                            active;
        logic [2:0]                      pos;
        logic [fiwc_pkg::TIMEOUT_CW-1:0] count;
        logic                            success;
    } fiwc_unl_regs_t;

    localparam logic [fiwc_pkg::TIMEOUT_CW-1:0] LIMIT =
        fiwc_pkg::TIMEOUT_CW'(TIMEOUT_TICKS);
    localparam logic [2:0] LAST_POS = 3'(fiwc_pkg::PAT_LEN - 1);

    fiwc_unl_regs_t r;
    fiwc_unl_regs_t next_r;

    always_comb
    begin
        next_r = r;
        next_r.success = 1'b0;
        if (start_in)
        begin
            next_r.active = 1'b1;
            next_r.pos    = 3'h0;
            next_r.count  = '0;
        end
        else if (r.active)
        begin
            if (sub_tick_in)
            begin
                next_r.count = r.count + 1'b1;
            end
            if (sub_tick_in && (r.count + 1'b1 >= LIMIT))
            begin
                next_r.active = 1'b0;
            end
            else if (byte_wr_in)
            begin
                if (byte_pos_in != r.pos ||
                    byte_in != fiwc_pkg::UNLOCK_PATTERN[r.pos])
                begin
                    next_r.active = 1'b0;
                end
                else if (r.pos == LAST_POS)
                begin
                    next_r.active  = 1'b0;
                    next_r.success = 1'b1;
                end
                else
                begin
                    next_r.pos = r.pos + 3'h1;
                end
            end
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign active_out  = r.active;
    assign success_out = r.success;

endmodule

// >>> testbench/fiwc_assertions.sv
`timescale 1ns/1ps

module fiwc_assertions #(
    parameter int ADDR_HI_BITS = 6
) (
    // Clock and reset
    input wire logic                clk_in,
    input wire logic                rstn_in,
    // Register port
    input wire fiwc_pkg::fiwc_bus_t bus_in,
    input wire logic [7:0]          rdata_out,
    // Flash side and status
    input wire logic                flash_req_valid_out,
    input wire fiwc_pkg::fiwc_req_t flash_req_out,
    input wire logic                flash_done_in,
    input wire logic                write_enabled_out,
    input wire logic                cpu_stall_out
);

    logic       pat_end;
    logic       ctrl_wr;
    logic       is_erase;
    logic [2:0] pat_hist;
    logic [7:0] unit_exp;

    default clocking chk_cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);

    ////////////////////////////////////////////////////////////////////////
    assign pat_end  = bus_in.wr && bus_in.addr == 4'hB
                      && bus_in.wdata == 8'h40;
    assign ctrl_wr  = bus_in.wr && bus_in.addr == fiwc_pkg::REG_CTRL;
    assign is_erase = flash_req_valid_out
                      && flash_req_out.op == fiwc_pkg::FIWC_OP_ERASE;
    assign unit_exp = (ADDR_HI_BITS == 4)
                      ? {4'h0, flash_req_out.addr[11:8]}
                      : 8'(flash_req_out.addr >> ADDR_HI_BITS);

    // A set may land up to two cycles after the last byte, so status
    // writes in that span are not judged
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            pat_hist <= 3'h0;
        else
            pat_hist <= {pat_hist[1:0], pat_end};
    end

    ////////////////////////////////////////////////////////////////////////
    a_stall_needs_op: assert property ($rose(cpu_stall_out) |->
        flash_req_valid_out && flash_req_out.op != fiwc_pkg::FIWC_OP_CLEAR)
        else $error("stall rose without a flash operation");
    a_clear_no_stall: assert property (flash_req_valid_out
        && flash_req_out.op == fiwc_pkg::FIWC_OP_CLEAR |-> !cpu_stall_out)
        else $error("buffer clear stalled the processor");
    a_stall_ends_done: assert property (
        cpu_stall_out && flash_done_in |=> !cpu_stall_out)
        else $error("stall held after operation end");
    a_locked_no_write: assert property (flash_req_valid_out
        && flash_req_out.op inside {fiwc_pkg::FIWC_OP_WRITE,
        fiwc_pkg::FIWC_OP_ERASE} |-> $past(write_enabled_out))
        else $error("write or erase issued while locked");
    a_unlock_cause: assert property (
        $rose(write_enabled_out) |-> |pat_hist[2:1])
        else $error("write enable set without final pattern byte");
    a_set_ignored: assert property (ctrl_wr && bus_in.wdata[7]
        && !write_enabled_out && !(|pat_hist[1:0]) |=> !write_enabled_out)
        else $error("software write set the enable status");
    a_status_clear: assert property (ctrl_wr && !bus_in.wdata[7]
        && !cpu_stall_out && !(|pat_hist[1:0]) |=> !write_enabled_out)
        else $error("enable status not cleared by software");
    a_addr_hi_zero: assert property (bus_in.rd
        && bus_in.addr == fiwc_pkg::REG_ADDR_HI
        |=> (rdata_out >> ADDR_HI_BITS) == 8'h00)
        else $error("unimplemented address bits read nonzero");
    a_erase_unit: assert property (
        is_erase |-> flash_req_out.erase_unit == unit_exp)
        else $error("erase unit does not match address");

    c_unlock: cover property ($rose(write_enabled_out));
    c_erase: cover property (is_erase);
    c_op_done: cover property (cpu_stall_out && flash_done_in);

endmodule

// >>> testbench/testbench.sv
`timescale 1ns/1ps

module testbench;

    typedef struct packed {
        logic [3:0] addr;
        logic       wr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } fiwc_row_t;

    logic                clk_in            = 1'h0;
    logic                rstn_in           = 1'h0;
    fiwc_pkg::fiwc_bus_t bus_in            = '0;
    logic [7:0]          rdata_out;
    logic                slow_sub_clock_in = 1'h0;
    logic                flash_req_valid_out;
    fiwc_pkg::fiwc_req_t flash_req_out;
    logic                flash_done_in     = 1'h0;
    logic [15:0]         flash_rdata_in    = 16'hBEEF;
    logic                write_enabled_out;
    logic                cpu_stall_out;
    int                  errors            = 0;
    int                  cmp_count         = 0;
    logic [5:0]          sub_div           = 6'h00;
    logic [7:0]          rd_val;
    fiwc_row_t           rows [16];
    logic [7:0]          pat [6];

    fiwc_top #(
        .ADDR_HI_BITS  (6),
        .TIMEOUT_TICKS (3)
    ) dut (
        .clk_in              (clk_in),
        .rstn_in             (rstn_in),
        .bus_in              (bus_in),
        .rdata_out           (rdata_out),
        .slow_sub_clock_in   (slow_sub_clock_in),
        .flash_req_valid_out (flash_req_valid_out),
        .flash_req_out       (flash_req_out),
        .flash_done_in       (flash_done_in),
        .flash_rdata_in      (flash_rdata_in),
        .write_enabled_out   (write_enabled_out),
        .cpu_stall_out       (cpu_stall_out)
    );

    initial
    begin
        forever #12.5 clk_in = ~clk_in;
    end

    // Sub clock period of 64 cycles: three ticks outlast a pattern write
    always @(posedge clk_in)
    begin
        sub_div <= sub_div + 6'h01;
        slow_sub_clock_in <= sub_div[5];
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic conclude();
        $display("Comparisons %0d, mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic check8(input string name, input logic [7:0] exp,
                          input logic [7:0] got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic check1(input string name, input logic exp,
                          input logic got);
        cmp_count++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
        end
    endtask

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_in);
        bus_in <= '{addr: a, wr: 1'h1, rd: 1'h0, wdata: d};
        @(posedge clk_in);
        bus_in <= '0;
    endtask

    task automatic rd_reg(input logic [3:0] a);
        @(posedge clk_in);
        bus_in <= '{addr: a, wr: 1'h0, rd: 1'h1, wdata: 8'h00};
        @(posedge clk_in);
        bus_in <= '0;
        #1 rd_val = rdata_out;
    endtask

    task automatic wait_req(input logic [3:0] op);
        int n;
        n = 0;
        #1;
        while (flash_req_valid_out !== 1'h1 && n < 20)
        begin
            @(posedge clk_in);
            #1 n++;
        end
        check1("request", 1'h1, flash_req_valid_out);
        if (n == 20)
            conclude();
        check8("operation", {4'h0, op}, {4'h0, flash_req_out.op});
    endtask

    task automatic op_done();
        repeat (4) @(posedge clk_in);
        flash_done_in <= 1'h1;
        @(posedge clk_in);
        flash_done_in <= 1'h0;
        #1;
    endtask

    task automatic unlock(input int bad, input int gap, input logic exp);
        wr_reg(fiwc_pkg::REG_CTRL, 8'h68);
        repeat (gap) @(posedge clk_in);
        for (int i = 0; i < 6; i++)
            wr_reg(4'(6 + i), (i == bad) ? ~pat[i] : pat[i]);
        repeat (4) @(posedge clk_in);
        #1 check1("write enabled", exp, write_enabled_out);
        $display("unlock test done");
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (20000) @(posedge clk_in);
        errors++;
        $display("[FAIL] run expected finished seen hung");
        conclude();
    end

    initial
    begin
        pat = '{8'h00, 8'h04, 8'h0D, 8'h09, 8'hC3, 8'h40};
        rows = '{'{4'h0, 1'h0, 8'h00, 8'h70}, '{4'h2, 1'h0, 8'h00, 8'h00},
                 '{4'h3, 1'h0, 8'h00, 8'h00}, '{4'h4, 1'h0, 8'h00, 8'h00},
                 '{4'hB, 1'h0, 8'h00, 8'h00}, '{4'h1, 1'h0, 8'h00, 8'h00},
                 '{4'h2, 1'h1, 8'hA5, 8'hA5}, '{4'h3, 1'h1, 8'hFF, 8'h3F},
                 '{4'h4, 1'h1, 8'h11, 8'h11}, '{4'h5, 1'h1, 8'h22, 8'h22},
                 '{4'h8, 1'h1, 8'h33, 8'h33}, '{4'hB, 1'h1, 8'h44, 8'h44},
                 '{4'hC, 1'h1, 8'h5A, 8'h00}, '{4'h0, 1'h1, 8'h24, 8'h20},
                 '{4'h0, 1'h1, 8'h80, 8'h00}, '{4'h7, 1'h1, 8'h66, 8'h66}};
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'h1;
        foreach (rows[i])
        begin
            if (rows[i].wr)
                wr_reg(rows[i].addr, rows[i].wdata);
            rd_reg(rows[i].addr);
            check8("register", rows[i].exp, rd_val);
        end
        $display("register test done");
        wr_reg(fiwc_pkg::REG_WBCLR, 8'h01);
        wait_req(fiwc_pkg::FIWC_OP_CLEAR);
        check1("stall in clear", 1'h0, cpu_stall_out);
        rd_reg(fiwc_pkg::REG_WBCLR);
        check8("clear bit busy", 8'h01, rd_val);
        op_done();
        rd_reg(fiwc_pkg::REG_WBCLR);
        check8("clear bit done", 8'h00, rd_val);
        $display("buffer clear test done");
        unlock(2, 0, 1'h0);
        unlock(6, 400, 1'h0);
        unlock(6, 0, 1'h1);
        wr_reg(fiwc_pkg::REG_CTRL, 8'h94);
        wait_req(fiwc_pkg::FIWC_OP_ERASE);
        check8("erase page", 8'hFE, flash_req_out.erase_unit);
        check1("stall erase", 1'h1, cpu_stall_out);
        op_done();
        check1("stall end", 1'h0, cpu_stall_out);
        wr_reg(fiwc_pkg::REG_WBCLR, 8'h01);
        wait_req(fiwc_pkg::FIWC_OP_CLEAR);
        op_done();
        wr_reg(fiwc_pkg::REG_CTRL, 8'h84);
        wait_req(fiwc_pkg::FIWC_OP_WRITE);
        check8("addr low", 8'hA5, flash_req_out.addr[7:0]);
        check8("addr high", 8'h3F, {2'h0, flash_req_out.addr[13:8]});
        check8("word1 high", 8'h04, flash_req_out.data[1][15:8]);
        op_done();
        rd_reg(fiwc_pkg::REG_CTRL);
        check8("write start", 8'h80, rd_val);
        wr_reg(fiwc_pkg::REG_CTRL, 8'hB3);
        wait_req(fiwc_pkg::FIWC_OP_READ);
        op_done();
        rd_reg(fiwc_pkg::REG_CTRL);
        check8("read start", 8'hB2, rd_val);
        rd_reg(4'h4);
        check8("read low", 8'hEF, rd_val);
        rd_reg(4'h5);
        check8("read high", 8'hBE, rd_val);
        $display("flash operation test done");
        wr_reg(fiwc_pkg::REG_CTRL, 8'h86);
        rd_reg(fiwc_pkg::REG_CTRL);
        check8("start with read enable", 8'h82, rd_val);
        wr_reg(fiwc_pkg::REG_CTRL, 8'h04);
        wr_reg(fiwc_pkg::REG_CTRL, 8'h84);
        rd_reg(fiwc_pkg::REG_CTRL);
        check8("locked write", 8'h00, rd_val);
        check1("write enabled", 1'h0, write_enabled_out);
        $display("lock test done");
        @(posedge clk_in);
        rstn_in <= 1'h0;
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'h1;
        rd_reg(fiwc_pkg::REG_CTRL);
        check8("ctrl after reset", 8'h70, rd_val);
        $display("reset test done");
        conclude();
    end

endmodule

bind fiwc_top fiwc_assertions #(.ADDR_HI_BITS(ADDR_HI_BITS)) u_chk (
    .clk_in              (clk_in),
    .rstn_in             (rstn_in),
    .bus_in              (bus_in),
    .rdata_out           (rdata_out),
    .flash_req_valid_out (flash_req_valid_out),
    .flash_req_out       (flash_req_out),
    .flash_done_in       (flash_done_in),
    .write_enabled_out   (write_enabled_out),
    .cpu_stall_out       (cpu_stall_out)
);
